// [hw/sxi_map.svh]
// Constants for the scalar-memory and vector-element issue block
`ifndef SXI_MAP_SVH
`define SXI_MAP_SVH
`define SXI_CLK_NS        8
`define SXI_IDX_W         6
`define SXI_AW            32
`define SXI_DW            64
`define SXI_OFS_W         22
`define SXI_BANK_BITS     4
`define SXI_IDX_K0        6'h01
`define SXI_ER_ISSUE_CP   1
`define SXI_EW_ISSUE_CP   2
`define SXI_ER_TAIL_CP    2
`define SXI_EW_TAIL_CP    3
`define SXI_RD_VIR_CP     8
`define SXI_RD_CIP_CP     11
`define SXI_EW_VREADY_CP  3
`define SXI_PARCEL_CP     3
`define SXI_MEM_SAME_CP   2
`define SXI_MEM_P0_CP     5
`define SXI_MEM_P2_CP     6
`define SXI_LD_MEM_CP     34
`define SXI_LD_CACHE_CP   7
`define SXI_BANK_CP       15
`endif

// [hw/sxi_pkg.sv]
// Types shared by the issue block and its helpers
package sxi_pkg;
  typedef enum logic [2:0] {
    SXI_OP_ER   = 3'h0,
    SXI_OP_EW   = 3'h1,
    SXI_OP_LA   = 3'h2,
    SXI_OP_SA   = 3'h3,
    SXI_OP_LS   = 3'h4,
    SXI_OP_SS   = 3'h5,
    SXI_OP_NONE = 3'h7
  } sxi_op_t;
  typedef enum logic [2:0] {
    SXI_ST_RUN    = 3'h1,
    SXI_ST_PARCEL = 3'h2,
    SXI_ST_GAP    = 3'h4
  } sxi_st_t;
endpackage : sxi_pkg

// [hw/sxi_cnt.sv]
// Loadable down counter used for latency and busy timing
`timescale 1ns/10ps
module sxi_cnt (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [5:0] val,
  output logic            busy,
  output logic            done
);
  import sxi_pkg::*;
  logic [5:0] cnt_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 6'h00;
    end else if (load) begin
      cnt_r <= val;
    end else if (cnt_r != 6'h00) begin
      cnt_r <= 6'(cnt_r - 6'h01);
    end
  end

  assign busy = (cnt_r != 6'h00);
  assign done = (cnt_r == 6'h01);
endmodule : sxi_cnt

// [hw/sxi_memfmt.sv]
// Address forming and word shaping for scalar memory access
`timescale 1ns/10ps
`include "sxi_map.svh"
module sxi_memfmt (
  input  wire logic [2:0]            fld_h,
  input  wire logic [`SXI_AW-1:0]    base_address_reg,
  input  wire logic [`SXI_OFS_W-1:0] immediate_offset_field,
  input  wire logic                  st_is_a,
  input  wire logic [`SXI_AW-1:0]    target_address_reg,
  input  wire logic [`SXI_DW-1:0]    store_scalar_reg,
  input  wire logic                  ld_is_a,
  input  wire logic [`SXI_DW-1:0]    mem_rdata,
  output logic [`SXI_AW-1:0]         addr,
  output logic [`SXI_DW-1:0]         st_word,
  output logic [`SXI_DW-1:0]         ld_word
);
  import sxi_pkg::*;
  logic [`SXI_AW-1:0] base_use;
  logic [`SXI_AW-1:0] ofs_ext;

  // Only the low 32 bits of the base take part; h of zero means offset alone
  assign base_use = (fld_h == 3'h0) ? 32'h0000_0000 : base_address_reg[31:0];
  assign ofs_ext  = {{(`SXI_AW-`SXI_OFS_W){1'b0}}, immediate_offset_field};
  assign addr     = 32'(base_use + ofs_ext);
  assign st_word  = st_is_a ? {32'h0000_0000, target_address_reg} : store_scalar_reg;
  assign ld_word  = ld_is_a ? {32'h0000_0000, mem_rdata[31:0]} : mem_rdata;
endmodule : sxi_memfmt

// [hw/sxi_issue.sv]
// Issue control for vector element transfers and scalar memory access
`timescale 1ns/10ps
`include "sxi_map.svh"
module sxi_issue (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  instr_valid,
  input  wire sxi_pkg::sxi_op_t      instr_op,
  input  wire logic [2:0]            fld_i,
  input  wire logic [2:0]            fld_j,
  input  wire logic [2:0]            fld_k,
  input  wire logic [2:0]            fld_h,
  input  wire logic [`SXI_OFS_W-1:0] immediate_offset_field,
  input  wire logic [`SXI_AW-1:0]    element_index_areg,
  input  wire logic [`SXI_AW-1:0]    base_address_reg,
  input  wire logic [`SXI_AW-1:0]    target_address_reg,
  input  wire logic [`SXI_DW-1:0]    src_scalar_reg,
  input  wire logic [`SXI_DW-1:0]    store_scalar_reg,
  input  wire logic [7:0]            a_resv,
  input  wire logic [7:0]            s_resv,
  input  wire logic [7:0]            v_resv,
  input  wire logic                  viq_full,
  input  wire logic                  blk_xfer_busy,
  input  wire logic                  port_a_busy,
  input  wire logic                  port_b_busy,
  input  wire logic                  parcel_missing,
  input  wire logic                  parcel0_split,
  input  wire logic                  parcel2_split,
  input  wire logic                  half_rate_cpu,
  input  wire logic                  sys_phase,
  input  wire logic                  cache_en,
  input  wire logic                  cache_hit,
  input  wire logic [`SXI_DW-1:0]    vu_rdata,
  input  wire logic [`SXI_DW-1:0]    mem_rdata,
  output logic                       issue_ack_r,
  output logic                       cip_busy_r,
  output logic                       vu_rd_req_r,
  output logic                       vu_wr_req_r,
  output logic [2:0]                 vu_vreg_r,
  output logic [`SXI_IDX_W-1:0]      vu_index_r,
  output logic [`SXI_DW-1:0]         vu_wdata_r,
  output logic                       vreg_ready_r,
  output logic [2:0]                 vreg_ready_sel_r,
  output logic                       xr_we_r,
  output logic [2:0]                 xr_sel_r,
  output logic [`SXI_DW-1:0]         xr_data_r,
  output logic                       mem_req_r,
  output logic                       mem_we_r,
  output logic [`SXI_AW-1:0]         mem_addr_r,
  output logic [`SXI_DW-1:0]         mem_wdata_r,
  output logic                       ld_a_we_r,
  output logic                       ld_s_we_r,
  output logic [2:0]                 ld_sel_r,
  output logic [`SXI_DW-1:0]         ld_data_r
);
  import sxi_pkg::*;
  localparam int NBANK = 1 << `SXI_BANK_BITS;

  sxi_st_t                   st_r, st_nxt;
  sxi_op_t                   last_op_r;
  logic [5:0]                wait_r, wait_nxt, gap_n, mem_n;
  logic                      par_ok_r;
  logic                      is_er, is_ew, is_xfer, is_mem, is_amem, is_ld;
  logic                      hold_x, hold_m, parcel_ok, sync_ok, go, vir_go;
  logic [`SXI_IDX_W-1:0]     k_idx;
  logic                      pend_r, ent_wr_r, ent_j0_r;
  logic [1:0]                vir_wait_r;
  logic [2:0]                ent_vreg_r, ent_dst_r, rd_dst_r, vr_dst_r, ld_dst_r;
  logic [`SXI_IDX_W-1:0]     ent_idx_r;
  logic [`SXI_DW-1:0]        ent_data_r;
  logic                      rd_j0_r, ld_isa_r, ld_cache_r, st_a_r;
  logic                      rd_busy, rd_done, vr_done, ld_busy, ld_done;
  logic [`SXI_AW-1:0]        fmt_addr;
  logic [`SXI_DW-1:0]        fmt_st, fmt_ld;
  logic [`SXI_BANK_BITS-1:0] addr_bank;
  logic [NBANK-1:0]          bank_busy;

  // Decode
  assign is_er   = (instr_op == SXI_OP_ER);
  assign is_ew   = (instr_op == SXI_OP_EW);
  assign is_xfer = is_er | is_ew;
  assign is_amem = (instr_op == SXI_OP_LA) | (instr_op == SXI_OP_SA);
  assign is_ld   = (instr_op == SXI_OP_LA) | (instr_op == SXI_OP_LS);
  assign is_mem  = is_amem | (instr_op == SXI_OP_LS) | (instr_op == SXI_OP_SS);

  assign k_idx = (fld_k == 3'h0) ? `SXI_IDX_K0 : element_index_areg[5:0];

  // The single vector stage entry and the read result timer are also holds,
  // so a second transfer never overwrites an entry still waiting there
  assign hold_x = ((fld_k != 3'h0) & a_resv[fld_k]) | viq_full
                | (is_er ? s_resv[fld_i] : s_resv[fld_j])
                | blk_xfer_busy
                | pend_r | (is_er & rd_busy);
  assign addr_bank = fmt_addr[`SXI_BANK_BITS-1:0];
  assign hold_m = port_a_busy | port_b_busy
                | ((fld_h != 3'h0) & a_resv[fld_h])
                | (is_amem ? a_resv[fld_i] : s_resv[fld_i])
                | bank_busy[addr_bank]
                | (is_ld & ld_busy);
  assign parcel_ok = ~parcel_missing | par_ok_r;
  assign sync_ok   = ~half_rate_cpu | sys_phase;
  assign go = instr_valid & (st_r == SXI_ST_RUN) & sync_ok
            & ((is_xfer & ~hold_x) | (is_mem & ~hold_m & parcel_ok));

  // Cycles the issue slot stays closed after the issue cycle itself
  assign mem_n = parcel0_split ? 6'(`SXI_MEM_P0_CP - 1) :
                 parcel2_split ? 6'(`SXI_MEM_P2_CP - 1) : 6'(`SXI_MEM_SAME_CP - 1);
  assign gap_n = is_er ? 6'(`SXI_ER_ISSUE_CP + `SXI_ER_TAIL_CP - 1) :
                 is_ew ? 6'(`SXI_EW_ISSUE_CP + `SXI_EW_TAIL_CP - 1) : mem_n;

  always_comb begin
    st_nxt   = st_r;
    wait_nxt = (wait_r != 6'h00) ? 6'(wait_r - 6'h01) : 6'h00;
    case (st_r)
      SXI_ST_RUN: begin
        if (go) begin
          st_nxt   = SXI_ST_GAP;
          wait_nxt = gap_n;
        end else if (instr_valid & is_mem & ~parcel_ok) begin
          st_nxt   = SXI_ST_PARCEL;
          // The cycle that finds the parcel missing counts as the first
          wait_nxt = 6'(`SXI_PARCEL_CP - 1);
        end
      end
      SXI_ST_PARCEL: begin
        if (wait_r == 6'h01) st_nxt = SXI_ST_RUN;
      end
      SXI_ST_GAP: begin
        if (wait_r == 6'h01) st_nxt = SXI_ST_RUN;
      end
      default: st_nxt = SXI_ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r        <= SXI_ST_RUN;
      wait_r      <= 6'h00;
      par_ok_r    <= 1'b0;
      issue_ack_r <= 1'b0;
      cip_busy_r  <= 1'b0;
      last_op_r   <= SXI_OP_NONE;
    end else begin
      st_r        <= st_nxt;
      wait_r      <= wait_nxt;
      par_ok_r    <= go ? 1'b0 : (par_ok_r | ((st_r == SXI_ST_PARCEL) & (wait_r == 6'h01)));
      issue_ack_r <= go;
      cip_busy_r  <= (st_nxt != SXI_ST_RUN);
      last_op_r   <= go ? instr_op : last_op_r;
    end
  end

  // Vector stage: entry reaches it three cycles after issue, then waits
  // for its vector register to be released
  assign vir_go = pend_r & (vir_wait_r == 2'h0) & ~v_resv[ent_vreg_r];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_r     <= 1'b0;
      vir_wait_r <= 2'h0;
      ent_wr_r   <= 1'b0;
      ent_j0_r   <= 1'b0;
      ent_vreg_r <= 3'h0;
      ent_dst_r  <= 3'h0;
      ent_idx_r  <= 6'h00;
      ent_data_r <= 64'h0;
    end else if (go & is_xfer) begin
      pend_r     <= 1'b1;
      vir_wait_r <= 2'(`SXI_RD_CIP_CP - `SXI_RD_VIR_CP - 1);
      ent_wr_r   <= is_ew;
      ent_j0_r   <= (fld_j == 3'h0);
      ent_vreg_r <= is_ew ? fld_i : fld_j;
      ent_dst_r  <= fld_i;
      ent_idx_r  <= k_idx;
      ent_data_r <= (fld_j == 3'h0) ? 64'h0 : src_scalar_reg;
    end else begin
      pend_r     <= pend_r & ~vir_go;
      vir_wait_r <= (vir_wait_r != 2'h0) ? 2'(vir_wait_r - 2'h1) : 2'h0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vu_rd_req_r <= 1'b0;
      vu_wr_req_r <= 1'b0;
      vu_vreg_r   <= 3'h0;
      vu_index_r  <= 6'h00;
      vu_wdata_r  <= 64'h0;
    end else begin
      vu_rd_req_r <= vir_go & ~ent_wr_r & ~ent_j0_r;
      vu_wr_req_r <= vir_go & ent_wr_r;
      if (vir_go) begin
        vu_vreg_r  <= ent_vreg_r;
        vu_index_r <= ent_idx_r;
        vu_wdata_r <= ent_data_r;
      end
    end
  end

  sxi_cnt u_rd (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (vir_go & ~ent_wr_r),
    .val      (6'(`SXI_RD_VIR_CP)),
    .busy     (rd_busy),
    .done     (rd_done)
  );

  sxi_cnt u_vr (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (vir_go & ent_wr_r),
    .val      (6'(`SXI_EW_VREADY_CP)),
    .busy     (),
    .done     (vr_done)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_dst_r         <= 3'h0;
      rd_j0_r          <= 1'b0;
      vr_dst_r         <= 3'h0;
      xr_we_r          <= 1'b0;
      xr_sel_r         <= 3'h0;
      xr_data_r        <= 64'h0;
      vreg_ready_r     <= 1'b0;
      vreg_ready_sel_r <= 3'h0;
    end else begin
      if (vir_go & ~ent_wr_r) begin
        rd_dst_r <= ent_dst_r;
        rd_j0_r  <= ent_j0_r;
      end
      if (vir_go & ent_wr_r) vr_dst_r <= ent_vreg_r;
      xr_we_r      <= rd_done;
      vreg_ready_r <= vr_done;
      if (rd_done) begin
        xr_sel_r  <= rd_dst_r;
        xr_data_r <= rd_j0_r ? 64'h0 : vu_rdata;
      end
      if (vr_done) vreg_ready_sel_r <= vr_dst_r;
    end
  end

  sxi_memfmt u_fmt (
    .fld_h                  (fld_h),
    .base_address_reg       (base_address_reg),
    .immediate_offset_field (immediate_offset_field),
    .st_is_a                (is_amem),
    .target_address_reg     (target_address_reg),
    .store_scalar_reg       (store_scalar_reg),
    .ld_is_a                (ld_isa_r),
    .mem_rdata              (mem_rdata),
    .addr                   (fmt_addr),
    .st_word                (fmt_st),
    .ld_word                (fmt_ld)
  );

  // One busy timer per bank; a bank count is fixed by the address bits used
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    sxi_cnt u_bank (
      .core_clk (core_clk),
      .reset    (reset),
      .load     (go & is_mem & (addr_bank == `SXI_BANK_BITS'(b))),
      .val      (6'(`SXI_BANK_CP)),
      .busy     (bank_busy[b]),
      .done     ()
    );
  end

  sxi_cnt u_ld (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (go & is_ld),
    .val      ((cache_en & cache_hit) ? 6'(`SXI_LD_CACHE_CP) : 6'(`SXI_LD_MEM_CP)),
    .busy     (ld_busy),
    .done     (ld_done)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= 32'h0000_0000;
      mem_wdata_r <= 64'h0;
      st_a_r      <= 1'b0;
    end else begin
      mem_req_r <= go & is_mem;
      if (go & is_mem) begin
        mem_we_r    <= ~is_ld;
        mem_addr_r  <= fmt_addr;
        mem_wdata_r <= is_ld ? 64'h0 : fmt_st;
        st_a_r      <= (instr_op == SXI_OP_SA);
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ld_dst_r   <= 3'h0;
      ld_isa_r   <= 1'b0;
      ld_cache_r <= 1'b0;
      ld_a_we_r  <= 1'b0;
      ld_s_we_r  <= 1'b0;
      ld_sel_r   <= 3'h0;
      ld_data_r  <= 64'h0;
    end else begin
      if (go & is_ld) begin
        ld_dst_r   <= fld_i;
        ld_isa_r   <= is_amem;
        ld_cache_r <= cache_en & cache_hit;
      end
      ld_a_we_r <= ld_done & ld_isa_r;
      ld_s_we_r <= ld_done & ~ld_isa_r;
      if (ld_done) begin
        ld_sel_r  <= ld_dst_r;
        ld_data_r <= fmt_ld;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_rd_done;
    ##9 xr_we_r;
  endsequence
  property p_rd_lat;
    (vir_go && !ent_wr_r) |-> s_rd_done;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("element read result late");
  property p_rd_zero;
    (vir_go && !ent_wr_r && ent_j0_r) |-> ##9 (xr_data_r == 64'h0);
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("zero source not zero");
  property p_idx_one;
    (go && is_xfer && fld_k == 3'h0) |=> (ent_idx_r == 6'h01);
  endproperty
  a_idx_one: assert property (p_idx_one) else $error("index zero not element one");
  property p_vr_ready;
    vu_wr_req_r |-> ##3 vreg_ready_r;
  endproperty
  a_vr_ready: assert property (p_vr_ready) else $error("vector ready timing");
  property p_ew_gap;
    (issue_ack_r && last_op_r == SXI_OP_EW) |=> !issue_ack_r [*4];
  endproperty
  a_ew_gap: assert property (p_ew_gap) else $error("issue too soon after write");
  property p_er_gap;
    (issue_ack_r && last_op_r == SXI_OP_ER) |=> !issue_ack_r [*2];
  endproperty
  a_er_gap: assert property (p_er_gap) else $error("issue too soon after read");
  property p_viq;
    (instr_valid && is_xfer && viq_full) |=> !issue_ack_r;
  endproperty
  a_viq: assert property (p_viq) else $error("issued with full queue");
  property p_ld_mem;
    (mem_req_r && !mem_we_r && !ld_cache_r) |-> ##34 (ld_a_we_r || ld_s_we_r);
  endproperty
  a_ld_mem: assert property (p_ld_mem) else $error("memory load latency");
  property p_ld_cache;
    (mem_req_r && !mem_we_r && ld_cache_r) |-> ##7 (ld_a_we_r || ld_s_we_r);
  endproperty
  a_ld_cache: assert property (p_ld_cache) else $error("cache load latency");
  property p_st_a;
    (mem_req_r && st_a_r) |-> (mem_wdata_r[63:32] == 32'h0000_0000);
  endproperty
  a_st_a: assert property (p_st_a) else $error("address store high bits set");
  property p_sync;
    issue_ack_r |-> (!$past(half_rate_cpu) || $past(sys_phase));
  endproperty
  a_sync: assert property (p_sync) else $error("issue off system clock phase");
  property p_parcel;
    (instr_valid && is_mem && !parcel_ok && st_r == SXI_ST_RUN) |=> !issue_ack_r [*3];
  endproperty
  a_parcel: assert property (p_parcel) else $error("missing parcel not delayed");
endmodule : sxi_issue

// [tb/sxi_far_model.sv]
// Far-side model: vector register file and central memory words
`timescale 1ns/10ps
`include "sxi_map.svh"
module sxi_far_model (
  input  wire logic                  core_clk,
  input  wire logic                  vu_rd_req_r,
  input  wire logic                  vu_wr_req_r,
  input  wire logic [2:0]            vu_vreg_r,
  input  wire logic [`SXI_IDX_W-1:0] vu_index_r,
  input  wire logic [`SXI_DW-1:0]    vu_wdata_r,
  input  wire logic                  mem_req_r,
  input  wire logic                  mem_we_r,
  input  wire logic [`SXI_AW-1:0]    mem_addr_r,
  input  wire logic [`SXI_DW-1:0]    mem_wdata_r,
  output logic [`SXI_DW-1:0]         vu_rdata,
  output logic [`SXI_DW-1:0]         mem_rdata
);
  logic [`SXI_DW-1:0] vreg [0:511];
  logic [`SXI_DW-1:0] mem  [0:255];
  logic [`SXI_DW-1:0] vval = '0;
  logic [`SXI_DW-1:0] mval = '0;
  int                 vcnt = 0;
  int                 mcnt = 0;
  assign vu_rdata  = vval;
  assign mem_rdata = mval;
  // Answers hold for a bounded window only, then toggle so a late sample shows up
  always @(posedge core_clk) begin
    if (vu_wr_req_r === 1'b1) vreg[{vu_vreg_r, vu_index_r}] <= vu_wdata_r;
    if (vu_rd_req_r === 1'b1) begin
      vval <= vreg[{vu_vreg_r, vu_index_r}];
      vcnt <= 10;
    end else if (vcnt > 0) vcnt <= vcnt - 1;
    else vval <= ~vval;
    if (mem_req_r === 1'b1 && mem_we_r === 1'b1) mem[mem_addr_r[7:0]] <= mem_wdata_r;
    if (mem_req_r === 1'b1 && mem_we_r === 1'b0) begin
      mval <= mem[mem_addr_r[7:0]];
      mcnt <= 40;
    end else if (mcnt > 0) mcnt <= mcnt - 1;
    else mval <= ~mval;
  end
endmodule : sxi_far_model

// [tb/sxi_issue_test.sv]
// Self-checking bench for the issue block with its far-side model
`timescale 1ns/10ps
`include "sxi_map.svh"
module sxi_issue_test;
  import sxi_pkg::*;
  logic core_clk = 0, reset = 1, instr_valid = 0, viq_full = 0, blk_xfer_busy = 0;
  logic port_a_busy = 0, port_b_busy = 0, parcel_missing = 0, parcel0_split = 0;
  logic parcel2_split = 0, half_rate_cpu = 0, sys_phase = 0, cache_en = 0, cache_hit = 0;
  sxi_op_t instr_op = SXI_OP_NONE;
  logic [2:0] fld_i = 0, fld_j = 0, fld_k = 0, fld_h = 0;
  logic [`SXI_OFS_W-1:0] immediate_offset_field = 0;
  logic [`SXI_AW-1:0] element_index_areg = 0, base_address_reg = 0, target_address_reg = 0;
  logic [`SXI_DW-1:0] src_scalar_reg = 0, store_scalar_reg = 0, vu_rdata, mem_rdata;
  logic [7:0] a_resv = 0, s_resv = 0, v_resv = 0;
  logic issue_ack_r, cip_busy_r, vu_rd_req_r, vu_wr_req_r, vreg_ready_r, xr_we_r, mem_req_r;
  logic mem_we_r, ld_a_we_r, ld_s_we_r;
  logic [2:0] vu_vreg_r, vreg_ready_sel_r, xr_sel_r, ld_sel_r;
  logic [`SXI_IDX_W-1:0] vu_index_r;
  logic [`SXI_DW-1:0] vu_wdata_r, xr_data_r, mem_wdata_r, ld_data_r;
  logic [`SXI_AW-1:0] mem_addr_r;
  wire  [5:0] ev = {mem_req_r, ld_a_we_r | ld_s_we_r, vu_wr_req_r, vreg_ready_r, xr_we_r,
                    issue_ack_r};
  int cyc = 0, checked = 0, n_mismatch = 0;

  sxi_issue sxi_issue_inst (.core_clk, .reset, .instr_valid, .instr_op, .fld_i, .fld_j,
    .fld_k, .fld_h, .immediate_offset_field, .element_index_areg, .base_address_reg,
    .target_address_reg, .src_scalar_reg, .store_scalar_reg, .a_resv, .s_resv, .v_resv,
    .viq_full, .blk_xfer_busy, .port_a_busy, .port_b_busy, .parcel_missing, .parcel0_split,
    .parcel2_split, .half_rate_cpu, .sys_phase, .cache_en, .cache_hit, .vu_rdata, .mem_rdata,
    .issue_ack_r, .cip_busy_r, .vu_rd_req_r, .vu_wr_req_r, .vu_vreg_r, .vu_index_r,
    .vu_wdata_r, .vreg_ready_r, .vreg_ready_sel_r, .xr_we_r, .xr_sel_r, .xr_data_r,
    .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r, .ld_a_we_r, .ld_s_we_r, .ld_sel_r,
    .ld_data_r);
  sxi_far_model sxi_far_model_inst (.core_clk, .vu_rd_req_r, .vu_wr_req_r, .vu_vreg_r,
    .vu_index_r, .vu_wdata_r, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r, .vu_rdata,
    .mem_rdata);

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits for one event bit, checking the current cycle first; a bounded wait
  task wait_ev(input int idx, output int c);
    int n;
    n = 0;
    while (ev[idx] !== 1'b1) begin
      @(posedge core_clk);
      #1;
      if (++n > 80) begin
        n_mismatch++;
        $display("mismatch at %0t: wait timed out", $time);
        summarize;
      end
    end
    c = cyc;
  endtask : wait_ev

  // Holds the request until acknowledged; a chained caller overwrites it right after
  task issue(input sxi_op_t op, input logic [2:0] i, j, k, h, input bit last, output int a);
    instr_op = op;
    fld_i = i;
    fld_j = j;
    fld_k = k;
    fld_h = h;
    instr_valid = 1;
    @(posedge core_clk);
    #1;
    wait_ev(0, a);
    if (last) instr_valid = 0;
  endtask : issue

  task t_elem;
    int a, b, c;
    src_scalar_reg = 64'h0123_4567_89AB_CDEF;
    issue(SXI_OP_EW, 3'h3, 3'h1, 3'h0, 3'h0, 1, a);
    chk(cip_busy_r, 1);
    wait_ev(3, b);
    chk(vu_index_r, 1);
    chk(vu_wdata_r, 64'h0123_4567_89AB_CDEF);
    wait_ev(2, c);
    chk(c - b, 3);
    chk(vreg_ready_sel_r, 3);
    chk(cip_busy_r, 0);
    issue(SXI_OP_ER, 3'h2, 3'h3, 3'h0, 3'h0, 1, a);
    wait_ev(1, c);
    chk(c - a, 11);
    chk(xr_data_r, 64'h0123_4567_89AB_CDEF);
    chk(xr_sel_r, 2);
    element_index_areg = 32'hFFFF_FFC5;
    issue(SXI_OP_EW, 3'h3, 3'h0, 3'h4, 3'h0, 1, a);
    wait_ev(3, b);
    chk(vu_index_r, 5);
    chk(vu_wdata_r, 0);
    issue(SXI_OP_ER, 3'h5, 3'h3, 3'h4, 3'h0, 1, a);
    wait_ev(1, c);
    chk(xr_data_r, 0);
    issue(SXI_OP_ER, 3'h6, 3'h0, 3'h4, 3'h0, 0, a);
    issue(SXI_OP_EW, 3'h1, 3'h1, 3'h4, 3'h0, 0, b);
    chk(64'(b - a >= 3), 1);
    issue(SXI_OP_ER, 3'h4, 3'h0, 3'h4, 3'h0, 1, c);
    chk(64'(c - b >= 5), 1);
    wait_ev(1, a);
    chk(xr_data_r, 0);
    chk(xr_sel_r, 4);
  endtask : t_elem

  task t_holds;
    int a;
    for (int c = 0; c < 8; c++) begin
      case (c)
        0: a_resv = 8'h20;
        1: viq_full = 1;
        2: blk_xfer_busy = 1;
        3: s_resv = 8'h08;
        4: half_rate_cpu = 1;
        5: port_a_busy = 1;
        6: a_resv = 8'h04;
        default: port_b_busy = 1;
      endcase
      instr_op = (c < 5) ? SXI_OP_EW : SXI_OP_SS;
      // A fresh bank each time so the bank timer cannot mask the hold
      immediate_offset_field = 22'(c);
      {fld_i, fld_j, fld_k, fld_h} = {3'h1, 3'h3, 3'h5, (c == 6) ? 3'h2 : 3'h0};
      instr_valid = 1;
      repeat (6) begin
        @(posedge core_clk);
        #1;
        chk(issue_ack_r, 0);
      end
      {a_resv, s_resv, viq_full, blk_xfer_busy, port_a_busy, port_b_busy} = '0;
      sys_phase = 1;
      wait_ev(0, a);
      instr_valid = 0;
      {half_rate_cpu, sys_phase} = 2'b00;
    end
    v_resv = 8'h02;
    issue(SXI_OP_EW, 3'h1, 3'h1, 3'h0, 3'h0, 1, a);
    repeat (6) begin
      @(posedge core_clk);
      #1;
      chk(vu_wr_req_r, 0);
    end
    v_resv = 8'h00;
    wait_ev(3, a);
    chk(vu_vreg_r, 1);
  endtask : t_holds

  task t_mem;
    int a, b, c;
    base_address_reg = 32'h0000_1000;
    immediate_offset_field = 22'h000123;
    store_scalar_reg = 64'hFEDC_BA98_7654_3210;
    issue(SXI_OP_SS, 3'h1, 3'h0, 3'h0, 3'h2, 1, a);
    wait_ev(5, b);
    chk(mem_addr_r, 32'h0000_1123);
    chk(mem_wdata_r, 64'hFEDC_BA98_7654_3210);
    chk(mem_we_r, 1);
    issue(SXI_OP_LA, 3'h3, 3'h0, 3'h0, 3'h2, 1, a);
    wait_ev(4, c);
    chk(c - a, 34);
    chk(ld_data_r, 64'h0000_0000_7654_3210);
    chk(ld_a_we_r, 1);
    chk(ld_sel_r, 3);
    base_address_reg = 32'hFFFF_0000;
    immediate_offset_field = 22'h001123;
    {cache_en, cache_hit} = 2'b11;
    issue(SXI_OP_LS, 3'h4, 3'h0, 3'h0, 3'h0, 1, a);
    wait_ev(5, b);
    chk(mem_addr_r, 32'h0000_1123);
    chk(mem_we_r, 0);
    wait_ev(4, c);
    chk(c - a, 7);
    chk(ld_data_r, 64'hFEDC_BA98_7654_3210);
    {cache_en, cache_hit} = 2'b00;
    target_address_reg = 32'hDEAD_BEEF;
    immediate_offset_field = 22'h000200;
    issue(SXI_OP_SA, 3'h4, 3'h0, 3'h0, 3'h0, 0, a);
    chk(mem_wdata_r, 64'h0000_0000_DEAD_BEEF);
    immediate_offset_field = 22'h000210;
    issue(SXI_OP_SS, 3'h2, 3'h0, 3'h0, 3'h0, 1, b);
    chk(64'(b - a >= 15), 1);
    for (int p = 0; p < 3; p++) begin
      {parcel0_split, parcel2_split} = (p == 0) ? 2'b00 : (p == 1) ? 2'b10 : 2'b01;
      immediate_offset_field = 22'(2 * p + 1);
      issue(SXI_OP_SS, 3'h1, 3'h0, 3'h0, 3'h0, 0, a);
      immediate_offset_field = 22'(2 * p + 2);
      issue(SXI_OP_SS, 3'h1, 3'h0, 3'h0, 3'h0, 1, b);
      chk(b - a, (p == 0) ? 2 : (p == 1) ? 5 : 6);
    end
    // Let the issue slot reopen first, or the gap adds to the measured parcel delay
    {parcel0_split, parcel2_split} = 2'b00;
    parcel_missing = 1;
    immediate_offset_field = 22'h000008;
    repeat (8) @(posedge core_clk);
    #1;
    c = cyc;
    issue(SXI_OP_SS, 3'h1, 3'h0, 3'h0, 3'h0, 1, a);
    chk(a - c, 4);
    parcel_missing = 0;
  endtask : t_mem

  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    reset = 0;
    t_elem;
    t_holds;
    t_mem;
    summarize;
  end
endmodule : sxi_issue_test
